// ===== core/scs_clock_select.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
// Overview of operation
// R1: source bit 1 takes external input, 0 takes internal RC oscillator.
// R2: fast cycle bit 1: twelve oscillator clocks per machine cycle, core at half.
// R3: fast cycle bit 0: halving divider bypassed, six oscillator clocks per cycle.
// R4: RC mode, frequency bit 1: RC output used at full rate.
// R5: RC mode, frequency bit 0: RC output passes the divide-by-2 stage.
// R6: gain bit 1 drives osc_gain_reduce_out high (reduced amplifier gain), 0 normal gain.
// R7: filter bit 1 inserts the clock noise filter into the input path.
// R8: unprogrammed configuration byte reads all ones.
// R9: clock settings sampled at reset and held, changed only glitch-free; watchdog bit follows the byte at once.
module scs_clock_select (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ext_clock_input_in,
  input  wire logic              rc_osc_in,
  input  wire scs_pkg::scs_addr_t addr_in,
  input  wire scs_pkg::scs_byte_t wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output scs_pkg::scs_byte_t     rd_data_out,
  output logic                   osc_tick_out,
  output logic                   core_clock_en_out,
  output logic                   peripheral_clock_en_out,
  output logic                   machine_cycle_out,
  output logic                   rc_osc_enable_out,
  output logic                   osc_gain_reduce_out,
  output logic                   input_clock_filter_enable_out,
  output logic                   watchdog_config_enable_out
);
  import scs_pkg::*;

  scs_byte_t   clock_config_byte;
  scs_source_e active_source;
  logic        active_fast_cycle;
  logic        active_rc_freq;
  logic        active_gain;
  logic        active_filter;
  logic        loaded;
  logic        pending;
  logic        ext_tick;
  logic        rc_tick;
  logic        rc_half;
  logic        rc_sys_tick;
  logic        sys_tick;
  logic        halve_phase;
  logic        core_tick;
  logic [2:0]  mc_count;
  logic        mc_end;
  logic        load_now;

  // register decode shared by read and write paths
  function automatic logic hit(input scs_addr_t a, input scs_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // external input path, filter under control of the held setting
  scs_edge_sync u_ext_sync (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .level_in     (ext_clock_input_in),
    .filter_en_in (active_filter), // R7
    .tick_out     (ext_tick)
  );

  // internal RC path, never filtered
  scs_edge_sync u_rc_sync (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .level_in     (rc_osc_in),
    .filter_en_in (1'b0),
    .tick_out     (rc_tick)
  );

  // configuration byte, reserved bits kept at one
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_config_byte <= `SCS_CONFIG_RESET; // R8
    end else if (wr_en_in && hit(addr_in, `SCS_OFS_CONFIG)) begin
      clock_config_byte <= wr_data_in | 8'h05;
    end
  end

  // reload request waits for a machine cycle boundary
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pending <= 1'b0;
    end else if (wr_en_in && hit(addr_in, `SCS_OFS_APPLY) && wr_data_in[`SCS_BIT_APPLY]) begin
      pending <= 1'b1;
    end else if (load_now) begin
      pending <= 1'b0;
    end
  end

  // first load right after reset release, later ones only between machine cycles
  assign load_now = !loaded || (pending && mc_end); // R9

  // held active settings
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      loaded            <= 1'b0;
      active_source     <= SCS_SRC_EXT;
      active_fast_cycle <= 1'b1;
      active_rc_freq    <= 1'b1;
      active_gain       <= 1'b1;
      active_filter     <= 1'b1;
    end else if (load_now) begin
      loaded            <= 1'b1;
      active_source     <= clock_config_byte[`SCS_BIT_SOURCE] ? SCS_SRC_EXT : SCS_SRC_RC; // R1
      active_fast_cycle <= clock_config_byte[`SCS_BIT_FAST_CYCLE]; // R9
      active_rc_freq    <= clock_config_byte[`SCS_BIT_RC_FREQ]; // R9
      active_gain       <= clock_config_byte[`SCS_BIT_GAIN]; // R9
      active_filter     <= clock_config_byte[`SCS_BIT_FILTER]; // R9
    end
  end

  // RC divide-by-2 stage, phase cleared whenever settings reload
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || load_now) begin
      rc_half <= 1'b0;
    end else if (rc_tick) begin
      rc_half <= ~rc_half;
    end
  end

  // full rate or every other RC edge
  assign rc_sys_tick = rc_tick && (active_rc_freq || rc_half); // R4 R5

  // system oscillator source mux
  assign sys_tick = (active_source == SCS_SRC_EXT) ? ext_tick : rc_sys_tick; // R1

  // halving divider for twelve-clock cycles
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || load_now) begin
      halve_phase <= 1'b0;
    end else if (sys_tick) begin
      halve_phase <= ~halve_phase;
    end
  end

  assign core_tick = sys_tick && (!active_fast_cycle || halve_phase); // R2 R3

  // six core periods per machine cycle in both modes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || load_now) begin
      mc_count <= 3'h0;
    end else if (core_tick) begin
      mc_count <= (mc_count == `SCS_CORE_PER_MC - 3'h1) ? 3'h0 : mc_count + 3'h1;
    end
  end

  assign mc_end = core_tick && (mc_count == `SCS_CORE_PER_MC - 3'h1); // R2 R3

  // registered clock enables
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      osc_tick_out            <= 1'b0;
      core_clock_en_out       <= 1'b0;
      peripheral_clock_en_out <= 1'b0;
      machine_cycle_out       <= 1'b0;
    end else begin
      osc_tick_out            <= sys_tick;
      core_clock_en_out       <= core_tick; // R2 R3
      peripheral_clock_en_out <= core_tick; // R2 R3
      machine_cycle_out       <= mc_end;
    end
  end

  // registered analogue controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rc_osc_enable_out             <= 1'b0;
      osc_gain_reduce_out           <= 1'b1;
      input_clock_filter_enable_out <= 1'b1;
      watchdog_config_enable_out    <= 1'b1;
    end else begin
      rc_osc_enable_out             <= (active_source == SCS_SRC_RC); // R1
      osc_gain_reduce_out           <= active_gain; // R6
      input_clock_filter_enable_out <= active_filter; // R7
      watchdog_config_enable_out    <= clock_config_byte[`SCS_BIT_WDT_CFG];
    end
  end

  // read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_en_in && hit(addr_in, `SCS_OFS_CONFIG)) begin
      rd_data_out <= clock_config_byte; // R8
    end else if (rd_en_in && hit(addr_in, `SCS_OFS_STATUS)) begin
      rd_data_out <= {loaded, pending, active_fast_cycle, active_gain, active_filter,
                      active_rc_freq, 1'b0, (active_source == SCS_SRC_EXT)};
    end else begin
      rd_data_out <= 8'h00;
    end
  end
endmodule

// ===== core/scs_defines.svh
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// register offsets (word index on the plain port)
`define SCS_OFS_CONFIG      4'h0
`define SCS_OFS_APPLY       4'h1
`define SCS_OFS_STATUS      4'h2

// clock configuration byte field positions
`define SCS_BIT_WDT_CFG     7
`define SCS_BIT_FAST_CYCLE  6
`define SCS_BIT_GAIN        5
`define SCS_BIT_FILTER      4
`define SCS_BIT_RC_FREQ     3
`define SCS_BIT_RSVD2       2
`define SCS_BIT_SOURCE      1
`define SCS_BIT_RSVD0       0

// unprogrammed value of the configuration byte
`define SCS_CONFIG_RESET    8'hff

// apply register: bit 0 requests a reload of the active settings
`define SCS_BIT_APPLY       0

// status register field positions
`define SCS_BIT_ST_LOADED   7
`define SCS_BIT_ST_PENDING  6

// core clock periods per machine cycle in either cycle mode
`define SCS_CORE_PER_MC     3'h6
// oscillator clocks per machine cycle in the two modes
`define SCS_OSC_PER_MC_SLOW 12
`define SCS_OSC_PER_MC_FAST 6

`endif

// ===== core/scs_pkg.sv
package scs_pkg;
  typedef logic [7:0] scs_byte_t;
  typedef logic [3:0] scs_addr_t;
  typedef enum logic [1:0] {
    SCS_SRC_RC  = 2'b01,
    SCS_SRC_EXT = 2'b10
  } scs_source_e;
endpackage

// ===== core/scs_edge_sync.sv
`timescale 1ns/1ps
// brings an asynchronous oscillator level into clk_in and emits one tick per rising edge
module scs_edge_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  input  wire logic filter_en_in,
  output logic      tick_out
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic clean;
  logic clean_d;

  // two-flop synchroniser, first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= level_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // noise filter: level moves only after two equal samples when enabled
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clean <= 1'b0;
    end else if (!filter_en_in || (sync_b == sync_c)) begin
      clean <= sync_b;
    end
  end

  // rising edge of the cleaned level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clean_d  <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      clean_d  <= clean;
      tick_out <= clean & ~clean_d;
    end
  end
endmodule

// ===== testbench/scs_clock_select_checker.sv
`timescale 1ns/1ps
// port-level relations of the clock selector
module scs_clock_select_checker (
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire scs_pkg::scs_addr_t addr_in,
  input wire logic               rd_en_in,
  input wire scs_pkg::scs_byte_t rd_data_out,
  input wire logic               osc_tick_out,
  input wire logic               core_clock_en_out,
  input wire logic               peripheral_clock_en_out,
  input wire logic               machine_cycle_out,
  input wire logic               osc_gain_reduce_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_periph_core_same: assert property (
    peripheral_clock_en_out == core_clock_en_out) else $error("periph differs");
  a_core_on_osc: assert property (
    core_clock_en_out |-> osc_tick_out) else $error("core tick without osc tick");
  a_cycle_on_core: assert property (
    machine_cycle_out |-> core_clock_en_out) else $error("cycle end off core tick");
  a_cycle_spacing: assert property (
    machine_cycle_out |=> !machine_cycle_out [*5]) else $error("cycle too short");
  a_rd_idle_zero: assert property (
    !$past(rd_en_in) |-> rd_data_out == 8'h00) else $error("read data outside slot");
  a_cfg_rsvd_ones: assert property (
    $past(rd_en_in) && $past(addr_in) == 4'h0 |-> rd_data_out[2] && rd_data_out[0])
    else $error("reserved bits not one");
  a_unmapped_zero: assert property (
    $past(rd_en_in) && $past(addr_in) > 4'h2 |-> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_gain_held: assert property (
    $changed(osc_gain_reduce_out) |-> machine_cycle_out || $past(machine_cycle_out)
    || $past(machine_cycle_out, 2)) else $error("setting changed mid cycle");
endmodule

// ===== testbench/scs_osc_model.sv
`timescale 1ns/1ps
// free-running crystal and rc oscillator levels
module scs_osc_model #(
  parameter real EXT_HALF = 15.0,
  parameter real RC_HALF  = 20.0
) (
  output logic ext_clock_input_out,
  output logic rc_osc_out
);
  // crystal starts at an odd offset, unrelated to the system clock
  initial begin
    ext_clock_input_out = 1'b0;
    #7.3;
    forever #(EXT_HALF) ext_clock_input_out = ~ext_clock_input_out;
  end
  // rc oscillator
  initial begin
    rc_osc_out = 1'b0;
    forever #(RC_HALF) rc_osc_out = ~rc_osc_out;
  end
endmodule

// ===== testbench/system_clock_source_and_cycle_select_bench.sv
`timescale 1ns/1ps
`include "scs_defines.svh"
module system_clock_source_and_cycle_select_bench;
  import scs_pkg::*;
  logic      clk, rst_n, we, re, ext, rc, ot, ct, pc, mc, ren, gn, fl, wd;
  scs_addr_t ad;
  scs_byte_t wd_in, rdat;
  int        n_mismatch = 0, cmp_count = 0, on = 0, cn = 0, rn = 0, en = 0, pn = 0, mn = 0;
  int        d_r, d_e, d_o, d_c, d_p, d_m;
  wire [7:0] lv = {4'h0, ren, gn, fl, wd};
  scs_clock_select DUT (.clk_in(clk), .rst_n_in(rst_n), .ext_clock_input_in(ext),
    .rc_osc_in(rc), .addr_in(ad), .wr_data_in(wd_in), .wr_en_in(we), .rd_en_in(re),
    .rd_data_out(rdat), .osc_tick_out(ot), .core_clock_en_out(ct),
    .peripheral_clock_en_out(pc), .machine_cycle_out(mc), .rc_osc_enable_out(ren),
    .osc_gain_reduce_out(gn), .input_clock_filter_enable_out(fl),
    .watchdog_config_enable_out(wd));
  scs_osc_model osc (.ext_clock_input_out(ext), .rc_osc_out(rc));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // tallies of ticks and source edges
  always @(posedge clk) begin
    on <= on + int'(ot);
    cn <= cn + int'(ct);
    pn <= pn + int'(pc);
    mn <= mn + int'(mc);
  end
  always @(posedge rc) rn++;
  always @(posedge ext) en++;
  task automatic cmp_byte(input scs_byte_t g, input scs_byte_t x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic cmp_near(input int g, input int x);
    cmp_count++;
    if (g < x - 3 || g > x + 3) begin
      n_mismatch++;
      $display("FAIL %0t count %0d want %0d", $time, g, x);
    end
  endtask
  task automatic wr(input scs_addr_t a, input scs_byte_t d);
    @(posedge clk);
    we <= 1'b1;
    ad <= a;
    wd_in <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rdc(input scs_addr_t a, input scs_byte_t x);
    @(posedge clk);
    re <= 1'b1;
    ad <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 cmp_byte(rdat, x);
  endtask
  // tick counts over 800 cycles
  task automatic measure();
    int r0, e0, o0, c0, p0, m0;
    r0 = rn;
    e0 = en;
    o0 = on;
    c0 = cn;
    p0 = pn;
    m0 = mn;
    repeat (800) @(posedge clk);
    d_r = rn - r0;
    d_e = en - e0;
    d_o = on - o0;
    d_c = cn - c0;
    d_p = pn - p0;
    d_m = mn - m0;
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    we = 1'b0;
    re = 1'b0;
    ad = 4'h0;
    wd_in = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`SCS_OFS_CONFIG, 8'hff);
    cmp_byte(lv, 8'h07);
    measure();
    cmp_near(d_o, d_e);
    cmp_near(d_c, d_o / 2);
    cmp_near(d_p, d_c);
    cmp_near(d_m, d_c / 6);
    wr(`SCS_OFS_CONFIG, 8'h00);
    rdc(`SCS_OFS_CONFIG, 8'h05);
    rdc(4'hf, 8'h00);
    cmp_byte(lv, 8'h06);
    wr(`SCS_OFS_APPLY, 8'h01);
    for (int i = 0; i < 400 && ren !== 1'b1; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    cmp_byte(lv, 8'h08);
    measure();
    cmp_near(d_o, d_r / 2);
    cmp_near(d_c, d_o);
    cmp_near(d_p, d_c);
    cmp_near(d_m, d_c / 6);
    wr(`SCS_OFS_CONFIG, 8'hd8);
    wr(`SCS_OFS_APPLY, 8'h01);
    for (int i = 0; i < 400 && fl !== 1'b1; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    cmp_byte(lv, 8'h0b);
    rdc(`SCS_OFS_STATUS, 8'hac);
    measure();
    cmp_near(d_o, d_r);
    cmp_near(d_c, d_o / 2);
    // reset in mid-run brings back the unprogrammed byte
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`SCS_OFS_CONFIG, 8'hff);
    cmp_byte(lv, 8'h07);
    close_out();
  end
endmodule
bind scs_clock_select scs_clock_select_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .osc_tick_out(osc_tick_out), .core_clock_en_out(core_clock_en_out),
  .peripheral_clock_en_out(peripheral_clock_en_out), .machine_cycle_out(machine_cycle_out),
  .osc_gain_reduce_out(osc_gain_reduce_out));
